// *** hdl/qpsd_map.vh ***
// Constants for the quad potentiometer serial command decoder.
// Assumes a 100 ns system clock; all counts derive from that period.
`ifndef QPSD_MAP_VH
`define QPSD_MAP_VH

// ****************************************
// Clock and timing figures
// ****************************************
`define QPSD_CLK_PERIOD_NS      100
// Wiper settle after a command or after power-up, 5 us to 10 us.
`define QPSD_SETTLE_MIN_NS      5000
`define QPSD_SETTLE_MAX_NS      10000
// Cycle counts are the figures above over the clock period, written at
// the width of the counter that loads them so no load cuts bits.
// The settle count uses the minimum so the tap moves as early as allowed.
`define QPSD_SETTLE_CYC         8'h32
// Power-up wait before the host may read or write, 1 ms.
`define QPSD_POWERUP_WAIT_US    1000
`define QPSD_POWERUP_CYC        16'h2710
// Nonvolatile write time, at most 5 ms.
`define QPSD_NV_WRITE_US        5000
`define QPSD_NV_WRITE_CYC       16'hc350

// ****************************************
// Field positions
// ****************************************
`define QPSD_TYPE_MSB           7
`define QPSD_TYPE_LSB           4
`define QPSD_STRAP_MSB          1
`define QPSD_STRAP_LSB          0
`define QPSD_OPCODE_MSB         7
`define QPSD_OPCODE_LSB         4
`define QPSD_STORE_MSB          3
`define QPSD_STORE_LSB          2
`define QPSD_WIPER_MSB          1
`define QPSD_WIPER_LSB          0

// ****************************************
// Reset values
// ****************************************
`define QPSD_WIPER_RESET        8'h00

`endif

// *** hdl/qpsd_decoder.v ***
// Serial command decoder for a quad digital potentiometer.
// Assumes the SPI pins and straps are asynchronous to ref_clk_in and
// that the data-phase logic on the same clock supplies wiper writes.
// Notes on behaviour
// - First byte after select is address; upper nibble must match type.
// - Address bits one and zero must equal the strap pins.
// - Second byte is instruction; upper four bits are the opcode.
// - Instruction bits three and two select stored setting zero to three.
// - Instruction bits one and zero select one of four wipers.
// - Wiper moves 5 to 10 us after its position register changes.
// - After power-up each wiper reaches restored position in 5-10 us.
// - A stored setting change completes within 5 ms.
// - Nonvolatile commit starts when select rises after a write.
// - Write-in-progress flag reads one while the commit runs.
// - At power-up each wiper register loads from stored setting zero.
`timescale 1ns/10ps
`include "qpsd_map.vh"

module qpsd_decoder #(
    // Arbitrary identifier value, not tied to any real part.
    parameter [3:0]  DEVICE_TYPE  = 4'ha,
    parameter [15:0] POWERUP_CYC  = `QPSD_POWERUP_CYC,
    parameter [15:0] NV_WRITE_CYC = `QPSD_NV_WRITE_CYC
) (
    // Clock, reset and enable.
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire        clk_en_in,
    // Serial link pins, asynchronous.
    input  wire        spi_sck_in,
    input  wire        spi_cs_n_in,
    input  wire        spi_si_in,
    input  wire [1:0]  strap_address_field_in,
    // Stored setting zero of each pot, pot n in bits 8n+7..8n.
    input  wire [31:0] stored_setting_zero_in,
    // Wiper writes from the data-phase logic.
    input  wire        wiper_write_in,
    input  wire [1:0]  wiper_write_sel_in,
    input  wire [7:0]  wiper_write_data_in,
    // A complete data-register write sequence has been received.
    input  wire        nv_write_seq_in,
    // Decoded command.
    output wire        cmd_valid_out,
    output reg  [3:0]  operation_code_field_out,
    output reg  [1:0]  store_select_out,
    output reg  [1:0]  wiper_select_out,
    output wire        data_phase_out,
    // Wiper registers and settled tap positions.
    output reg  [31:0] wiper_position_reg_out,
    output reg  [31:0] wiper_tap_out,
    output wire        wiper_settling_out,
    // Readiness and nonvolatile write status.
    output wire        powerup_ready_out,
    output wire        nv_commit_out,
    output wire        write_in_progress_flag_out
);

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_INSTR  = 3'h2;
    localparam [2:0] ST_DATA   = 3'h3;
    localparam [2:0] ST_IGNORE = 3'h4;
    localparam [7:0] SETTLE_CYC = `QPSD_SETTLE_CYC;

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg  [4:0]  sync1;
    reg  [4:0]  sync2;
    reg         sck_prev;
    reg         cs_n_prev;
    wire        sck_s   = sync2[0];
    wire        cs_n_s  = sync2[1];
    wire        si_s    = sync2[2];
    wire [1:0]  strap_s = sync2[4:3];
    wire        sck_rise = sck_s & ~sck_prev;
    wire        cs_rise  = cs_n_s & ~cs_n_prev;

    // Reset values match the idle pins (select high, clock low), so no
    // false clock edge is seen on the first cycles after reset.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1     <= 5'h02;
            sync2     <= 5'h02;
            sck_prev  <= 1'b0;
            cs_n_prev <= 1'b1;
        end else if (clk_en_in) begin
            sync1     <= {strap_address_field_in, spi_si_in,
                          spi_cs_n_in, spi_sck_in};
            sync2     <= sync1;
            sck_prev  <= sck_s;
            cs_n_prev <= cs_n_s;
        end
    end

    // ****************************************
    // Command byte state machine
    // ****************************************
    reg  [2:0]  state;
    reg  [2:0]  bit_cnt;
    reg  [6:0]  shift;
    reg         cmd_pulse;
    wire [7:0]  byte_in = {shift, si_s};
    wire        byte_done = sck_rise && (bit_cnt == 3'h7);

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state                    <= ST_IDLE;
            bit_cnt                  <= 3'h0;
            shift                    <= 7'h00;
            cmd_pulse                <= 1'b0;
            operation_code_field_out <= 4'h0;
            store_select_out         <= 2'h0;
            wiper_select_out         <= 2'h0;
        end else if (clk_en_in) begin
            cmd_pulse <= 1'b0;
            if (sck_rise) begin
                shift   <= byte_in[6:0];
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (cs_n_s) begin
                state   <= ST_IDLE;
                bit_cnt <= 3'h0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        state   <= ST_ADDR;
                        bit_cnt <= sck_rise ? 3'h1 : 3'h0;
                    end
                    ST_ADDR: begin
                        if (byte_done) begin
                            if (byte_in[`QPSD_TYPE_MSB:`QPSD_TYPE_LSB]
                                    == DEVICE_TYPE &&
                                byte_in[`QPSD_STRAP_MSB:`QPSD_STRAP_LSB]
                                    == strap_s)
                                state <= ST_INSTR;
                            else
                                state <= ST_IGNORE;
                        end
                    end
                    ST_INSTR: begin
                        if (byte_done) begin
                            state     <= ST_DATA;
                            cmd_pulse <= 1'b1;
                            operation_code_field_out <=
                                byte_in[`QPSD_OPCODE_MSB:`QPSD_OPCODE_LSB];
                            store_select_out <=
                                byte_in[`QPSD_STORE_MSB:`QPSD_STORE_LSB];
                            wiper_select_out <=
                                byte_in[`QPSD_WIPER_MSB:`QPSD_WIPER_LSB];
                        end
                    end
                    ST_DATA:   state <= ST_DATA;
                    ST_IGNORE: state <= ST_IGNORE;
                    default:   state <= ST_IDLE;
                endcase
            end
        end
    end

    assign cmd_valid_out  = cmd_pulse;
    assign data_phase_out = (state == ST_DATA);

    // ****************************************
    // Power-up readiness and wiper restore
    // ****************************************
    // The reset release stands in for supply stable; the stored values
    // are caught by a clocked load one cycle after release.
    reg  [15:0] pwr_cnt;
    reg         load_done;
    reg  [7:0]  settle_cnt;
    reg         settle_busy;
    wire [31:0] next_wiper;

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            pwr_cnt <= 16'h0000;
        else if (clk_en_in && pwr_cnt != POWERUP_CYC)
            pwr_cnt <= pwr_cnt + 16'h0001;
    end
    assign powerup_ready_out = (pwr_cnt == POWERUP_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pot
            assign next_wiper[8*gi+7:8*gi] =
                !load_done ? stored_setting_zero_in[8*gi+7:8*gi] :
                (wiper_write_in && {30'h0, wiper_write_sel_in} == gi) ?
                    wiper_write_data_in :
                    wiper_position_reg_out[8*gi+7:8*gi];
        end
    endgenerate

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_done              <= 1'b0;
            wiper_position_reg_out <= {4{`QPSD_WIPER_RESET}};
            wiper_tap_out          <= {4{`QPSD_WIPER_RESET}};
            settle_cnt             <= 8'h00;
            settle_busy            <= 1'b0;
        end else if (clk_en_in) begin
            load_done              <= 1'b1;
            wiper_position_reg_out <= next_wiper;
            if (!load_done || wiper_write_in) begin
                settle_cnt  <= SETTLE_CYC;
                settle_busy <= 1'b1;
            end else if (settle_busy) begin
                if (settle_cnt == 8'h01) begin
                    settle_busy   <= 1'b0;
                    wiper_tap_out <= wiper_position_reg_out;
                end
                settle_cnt <= settle_cnt - 8'h01;
            end
        end
    end
    assign wiper_settling_out = settle_busy;

    // ****************************************
    // Nonvolatile commit timing
    // ****************************************
    // A write sequence only arms the commit; select rising starts it, so
    // a host that aborts mid-byte never triggers a cycle.
    reg         nv_armed;
    reg         nv_start;
    reg  [15:0] nv_cnt;

    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            nv_armed <= 1'b0;
            nv_start <= 1'b0;
            nv_cnt   <= 16'h0000;
        end else if (clk_en_in) begin
            nv_start <= 1'b0;
            if (cs_rise && nv_armed) begin
                nv_armed <= 1'b0;
                nv_start <= 1'b1;
                nv_cnt   <= NV_WRITE_CYC;
            end else begin
                // Arming is refused once select is seen high, so a late
                // sequence flag cannot linger into the next frame.
                if (nv_write_seq_in && state == ST_DATA && !cs_n_s)
                    nv_armed <= 1'b1;
                if (nv_cnt != 16'h0000)
                    nv_cnt <= nv_cnt - 16'h0001;
            end
        end
    end

    assign nv_commit_out = nv_start;
    assign write_in_progress_flag_out = (nv_cnt != 16'h0000);

endmodule // qpsd_decoder

// *** verification/qpsd_decoder_sva.sv ***
// Port timing checker for the serial command decoder.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
module qpsd_decoder_sva #(
    parameter [15:0] NV_WRITE_CYC = 16'h001e
) (
    // Clock and reset.
    input wire        ref_clk_in,
    input wire        rst_in,
    // Watched inputs.
    input wire        spi_cs_n_in,
    input wire        wiper_write_in,
    input wire [1:0]  wiper_write_sel_in,
    input wire [7:0]  wiper_write_data_in,
    // Watched outputs.
    input wire        cmd_valid_out,
    input wire [3:0]  operation_code_field_out,
    input wire [1:0]  store_select_out,
    input wire [1:0]  wiper_select_out,
    input wire        data_phase_out,
    input wire [31:0] wiper_position_reg_out,
    input wire [31:0] wiper_tap_out,
    input wire        wiper_settling_out,
    input wire        nv_commit_out,
    input wire        write_in_progress_flag_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    reg [15:0] busy_len;
    // Length of the current busy stretch, kept for the fall check.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            busy_len <= 16'h0000;
        else if (write_in_progress_flag_out)
            busy_len <= busy_len + 16'h0001;
        else
            busy_len <= 16'h0000;
    end
    property p_cmd_in_frame; cmd_valid_out |-> !$past(spi_cs_n_in, 2);
    endproperty
    a_cmd_in_frame: assert property (p_cmd_in_frame)
        else $error("command outside a frame");
    property p_cmd_pulse; cmd_valid_out |=> !cmd_valid_out; endproperty
    a_cmd_pulse: assert property (p_cmd_pulse)
        else $error("command pulse too long");
    property p_phase; cmd_valid_out |=> data_phase_out; endproperty
    a_phase: assert property (p_phase)
        else $error("no data phase after command");
    property p_fields_hold; !cmd_valid_out |-> $stable({
        operation_code_field_out, store_select_out, wiper_select_out});
    endproperty
    a_fields_hold: assert property (p_fields_hold)
        else $error("fields changed without a command");
    property p_commit_busy; nv_commit_out |-> write_in_progress_flag_out [*8];
    endproperty
    a_commit_busy: assert property (p_commit_busy)
        else $error("busy flag not raised by commit");
    property p_busy_full;
        $fell(write_in_progress_flag_out) |-> busy_len == NV_WRITE_CYC;
    endproperty
    a_busy_full: assert property (p_busy_full)
        else $error("busy stretch has wrong length");
    property p_commit_cs; nv_commit_out |-> spi_cs_n_in; endproperty
    a_commit_cs: assert property (p_commit_cs)
        else $error("commit while selected");
    property p_wiper_load; wiper_write_in |=> wiper_position_reg_out[
        {$past(wiper_write_sel_in), 3'b000} +: 8] == $past(wiper_write_data_in);
    endproperty
    a_wiper_load: assert property (p_wiper_load)
        else $error("wiper register not loaded");
    property p_settle; wiper_write_in |-> ##2 wiper_settling_out; endproperty
    a_settle: assert property (p_settle)
        else $error("settling not started");
    property p_tap; $changed(wiper_tap_out) |->
        wiper_tap_out == wiper_position_reg_out; endproperty
    a_tap: assert property (p_tap)
        else $error("tap differs from wiper register");
    c_cmd: cover property (cmd_valid_out);
    c_commit: cover property (nv_commit_out);
    c_settled: cover property ($fell(wiper_settling_out));
endmodule // qpsd_decoder_sva

bind qpsd_decoder qpsd_decoder_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_sva (
    .ref_clk_in, .rst_in, .spi_cs_n_in, .wiper_write_in, .wiper_write_sel_in,
    .wiper_write_data_in, .cmd_valid_out, .operation_code_field_out,
    .store_select_out, .wiper_select_out, .data_phase_out,
    .wiper_position_reg_out, .wiper_tap_out, .wiper_settling_out,
    .nv_commit_out, .write_in_progress_flag_out);

// *** verification/qpsd_spi_host.sv ***
// Serial host model driving select, clock and data into the decoder.
// Assumes ref_clk_in is the bench clock; one serial period is 8 cycles.
`timescale 1ns/10ps
module qpsd_spi_host (
    input  wire ref_clk_in,
    output reg  spi_sck_out,
    output reg  spi_cs_n_out,
    output reg  spi_si_out
);
    initial begin
        spi_sck_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_si_out = 1'b0;
    end
    task send(input [15:0] word, input integer nbits);
        integer i;
        begin
            @(posedge ref_clk_in) spi_cs_n_out <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
            for (i = 15; i > 15 - nbits; i = i - 1) begin
                spi_si_out <= word[i];
                repeat (4) @(posedge ref_clk_in);
                spi_sck_out <= 1'b1;
                repeat (4) @(posedge ref_clk_in);
                spi_sck_out <= 1'b0;
            end
            repeat (8) @(posedge ref_clk_in);
        end
    endtask
    // select high closes
    // Released data is inverted so a stale level never looks valid.
    task stop;
        begin
            @(posedge ref_clk_in) spi_cs_n_out <= 1'b1;
            spi_si_out <= ~spi_si_out;
            repeat (12) @(posedge ref_clk_in);
        end
    endtask
endmodule // qpsd_spi_host

// *** verification/qpsd_decoder_tb_top.sv ***
// Self-checking bench for the serial command decoder.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module qpsd_decoder_tb_top;
    localparam [3:0] DEV_TYPE = 4'h6; // Arbitrary type value.
    reg         ref_clk_in, rst_in, clk_en_in, wiper_write_in, nv_write_seq_in;
    reg  [1:0]  strap, sel;
    reg  [7:0]  data, addr, got;
    reg  [15:0] lfsr_val;
    reg  [31:0] stored, exp_w;
    wire        sck, cs_n, si, cmd_valid, phase, settling, ready, commit, write_in_progress_flag;
    wire [3:0]  opcode;
    wire [1:0]  store_sel, wiper_sel;
    wire [31:0] wiper_reg, tap;
    integer     error_cnt, cmp_count, cycles, commits, busy, i;
    reg  [7:0]  exp_q[$];
    qpsd_spi_host u_host (.ref_clk_in(ref_clk_in), .spi_sck_out(sck),
        .spi_cs_n_out(cs_n), .spi_si_out(si));
    qpsd_decoder #(.DEVICE_TYPE(DEV_TYPE), .POWERUP_CYC(16'h0014),
        .NV_WRITE_CYC(16'h001e)) u_dut (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .clk_en_in(clk_en_in), .spi_sck_in(sck),
        .spi_cs_n_in(cs_n), .spi_si_in(si), .strap_address_field_in(strap),
        .stored_setting_zero_in(stored), .wiper_write_in(wiper_write_in),
        .wiper_write_sel_in(sel), .wiper_write_data_in(data),
        .nv_write_seq_in(nv_write_seq_in), .cmd_valid_out(cmd_valid),
        .operation_code_field_out(opcode), .store_select_out(store_sel),
        .wiper_select_out(wiper_sel), .data_phase_out(phase),
        .wiper_position_reg_out(wiper_reg), .wiper_tap_out(tap),
        .wiper_settling_out(settling), .powerup_ready_out(ready),
        .nv_commit_out(commit), .write_in_progress_flag_out(write_in_progress_flag));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task check(input [63:0] got_v, input [63:0] exp_v, input [8*8:1] what);
        begin
            cmp_count = cmp_count + 1;
            if (got_v !== exp_v) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: %0s got %h want %h", $time, what,
                    got_v, exp_v);
            end
        end
    endtask
    task summarize;
        begin
            $display("Checks %0d, errors %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Each decoded command must match the oldest one still expected.
    always @(posedge ref_clk_in) begin
        cycles = cycles + 1;
        commits = commits + (commit === 1'b1);
        busy = busy + (write_in_progress_flag === 1'b1);
        if (cmd_valid === 1'b1) begin
            got = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            check({opcode, store_sel, wiper_sel},
                got, "command");
        end
        if (cycles > 8000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    task frame(input [7:0] instr, input integer nbits, input ok);
        begin
            if (ok)
                exp_q.push_back(instr);
            u_host.send({addr, instr}, nbits);
            check(exp_q.size(), 0, "pending");
        end
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        {rst_in, clk_en_in, wiper_write_in, nv_write_seq_in} = 4'hc;
        {error_cnt, cmp_count, cycles, commits, busy} = 0;
        lfsr_val = 16'h1c39;
        {strap, sel, data} = lfsr_val[11:0];
        stored = {lfsr_val, ~lfsr_val};
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (60) @(posedge ref_clk_in);
        check(wiper_reg, stored, "restore");
        check(tap, stored, "tap");
        check(ready, 1, "ready");
        for (i = 0; i < 19; i = i + 1) begin
            lfsr_val = lfsr(lfsr_val);
            addr = {(i == 16) ? ~DEV_TYPE : DEV_TYPE, 2'b00,
                strap ^ {1'b0, i == 17}};
            frame({i[3:0], lfsr_val[3:0]},
                (i == 18) ? 10 : 16, i < 16);
            u_host.stop;
        end
        addr = {DEV_TYPE, 2'b00, strap};
        frame(8'hc5, 16, 1);
        @(posedge ref_clk_in) nv_write_seq_in <= 1'b1;
        @(posedge ref_clk_in) nv_write_seq_in <= 1'b0;
        u_host.stop;
        repeat (40) @(posedge ref_clk_in);
        check(commits, 1, "commits");
        check(busy, 30, "busy");
        @(posedge ref_clk_in) {sel, data} <= lfsr_val[9:0];
        wiper_write_in <= 1'b1;
        @(posedge ref_clk_in) wiper_write_in <= 1'b0;
        exp_w = stored;
        exp_w[8 * sel +: 8] = data;
        #1 check(wiper_reg, exp_w, "wiper");
        // Twenty frozen cycles must push the tap update back by twenty.
        repeat (10) @(posedge ref_clk_in);
        clk_en_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        clk_en_in <= 1'b1;
        repeat (35) @(posedge ref_clk_in);
        #1 check(tap, stored, "early");
        repeat (10) @(posedge ref_clk_in);
        #1 check(tap, exp_w, "settled");
        summarize;
    end
endmodule // qpsd_decoder_tb_top
